// ---- include/cdbi_defs.vh ----
// constants for the cpu data bus interface block
// assumes one clock, ref_clk, at 125 MHz
`ifndef CDBI_DEFS_VH
`define CDBI_DEFS_VH
`define CDBI_SIZE_BYTE  2'b00
`define CDBI_SIZE_HALF  2'b01
`define CDBI_SIZE_WORD  2'b10
`define CDBI_DOUT_RST   32'h00000000
`define CDBI_LANE3      31:24
`define CDBI_LANE2      23:16
`define CDBI_LANE1      15:8
`define CDBI_LANE0      7:0
`endif

// ---- sim/cdbi_checker.sv ----
// port assertions for the cpu data bus interface
// assumes binding onto cdbi_data_bus, one clock domain
module cdbi_checker (
    // clock and reset
    input logic        ref_clk,
    input logic        rst,
    // watched ports
    input logic        rspDone,
    input logic        dataAbortTrap,
    input logic        fetchAbortTag,
    input logic        bus_split_select,
    input logic [31:0] dataOut,
    input logic        write_not_read,
    input logic        drive_out_enable_n,
    input logic        addrOutEnN,
    input logic        sharedDataOutEnN,
    input logic        drive_in_gate_n,
    input logic        data_bus_enable,
    input logic        address_bus_enable,
    input logic        test_bus_enable,
    input logic        wait_n,
    input logic        abortIn
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_split_zero: assert property (
        !bus_split_select && !$past(bus_split_select) |-> dataOut == 32'h0)
        else $error("dout not zero");
    // two cycles of split mode so the registered output has settled
    chk_dout_store: assert property (
        $changed(dataOut) && bus_split_select && $past(bus_split_select, 2) |-> !drive_out_enable_n)
        else $error("dout changed outside a store");
    chk_drive_dir: assert property (
        !drive_out_enable_n |-> write_not_read) else $error("drive low on a read");
    chk_done_wait: assert property (
        rspDone |-> $past(wait_n)) else $error("cycle ended with wait low");
    chk_abort_cause: assert property (
        rspDone && !$past(abortIn) |-> !dataAbortTrap && !fetchAbortTag) else $error("stray abort");
    chk_abort_kind: assert property (
        dataAbortTrap || fetchAbortTag |-> rspDone && (dataAbortTrap ^ fetchAbortTag))
        else $error("abort kind wrong");
    chk_test_float: assert property (
        !test_bus_enable |=> addrOutEnN && sharedDataOutEnN) else $error("driven while test float");
    chk_addr_float: assert property (
        !rst |=> addrOutEnN == !$past(address_bus_enable && test_bus_enable))
        else $error("address enable wrong");
    chk_drive_gate: assert property (
        !sharedDataOutEnN |-> $past(!drive_in_gate_n && data_bus_enable && test_bus_enable))
        else $error("shared bus driven while gated");
    chk_drive_owned: assert property (
        !sharedDataOutEnN |-> !drive_out_enable_n) else $error("shared bus driven outside a write");
    cover property (dataAbortTrap);
    cover property (fetchAbortTag);
    cover property (!sharedDataOutEnN);
endmodule // cdbi_checker
bind cdbi_data_bus cdbi_checker i_chk (.*);

// ---- sim/cdbi_mem_model.sv ----
// memory controller model: one fixed word, wait states, halfword memory
// assumes reqValid high marks the edge where the core takes a request
module cdbi_mem_model (
    // clock and core side
    input  logic        ref_clk,
    input  logic        reqValid,
    input  logic        write_not_read,
    input  logic        bus_split_select,
    input  logic [31:0] addrOut,
    // bench settings
    input  logic [1:0]  waits,
    input  logic        narrow,
    // to core
    output logic [31:0] dataIn,
    output logic [31:0] sharedDataIn,
    output logic        wait_n,
    output logic        abortIn,
    output logic [3:0]  byte_latch_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] WORD = 32'h88776655;
    logic [1:0]  cnt = 2'h3;
    logic [31:0] w;
    always @(posedge ref_clk) cnt <= reqValid ? 2'h0 : (cnt == 2'h3 ? cnt : cnt + 2'h1);
    assign wait_n = cnt >= waits;
    // bit 31 aborts only where wait_n is high, so an early sample misses it;
    // bit 30 aborts only during wait cycles, which must not trap
    assign abortIn = (addrOut[31] && wait_n) || (addrOut[30] && !wait_n);
    assign byte_latch_enable = write_not_read || !narrow ? 4'hf
                             : (cnt == 2'h0 ? 4'h3 : 4'hc);
    // lanes not being filled carry inverted data so a wrong latch shows
    assign w = !narrow ? WORD
             : cnt == 2'h0 ? {~WORD[31:16], WORD[15:0]}
             : {WORD[31:16], ~WORD[15:0]};
    assign dataIn = bus_split_select ? w : ~w;
    assign sharedDataIn = bus_split_select || write_not_read ? ~w : w;
endmodule // cdbi_mem_model

// ---- sim/cdbi_tb.sv ----
// self-checking bench for cdbi_data_bus with the memory model
// assumes 125 MHz ref_clk and synchronous active high reset
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst = 1, reqValid = 0, reqWrite = 0, reqFetch = 0, reqUser = 0, reqLock = 0;
    logic bus_split_select = 1, big_endian_select = 0, drive_in_gate_n = 0, data_bus_enable = 1;
    logic address_bus_enable = 1, test_bus_enable = 1, narrow = 0, drv, dab, fab;
    logic [1:0] reqSize = 2'h2, waits = 2'h0, transfer_size;
    logic [31:0] reqAddr = 0, reqWdata = 0, rspData, addrOut, dataIn, dataOut;
    logic [31:0] sharedDataIn, sharedDataOut;
    logic [3:0] byte_latch_enable;
    logic rspDone, dataAbortTrap, fetchAbortTag, write_not_read, fetch_not, translate_not, lockOut;
    logic addrOutEnN, sharedDataOutEnN, drive_out_enable_n, wait_n, abortIn;
    int errors = 0, compares = 0, cyc = 0, n;
    // {size, addr[1:0], big endian, expected field}
    logic [36:0] rows [12] = '{37'h10_88776655, 37'h11_88776655, 37'h08_00006655, 37'h0c_00008877,
        37'h09_00008877, 37'h0d_00006655, 37'h00_00000055, 37'h02_00000066, 37'h04_00000077,
        37'h06_00000088, 37'h01_00000088, 37'h05_00000066};
    // {drive_in_gate_n, data_bus_enable, address_bus_enable, test_bus_enable}
    logic [3:0] en [6] = '{4'hf, 4'h3, 4'h5, 4'h6, 4'h0, 4'h7};
    cdbi_data_bus i_dut (.*);
    cdbi_mem_model i_mem (.*);
    always #4 ref_clk = ~ref_clk;
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic acc(input logic wr, fe, input logic [1:0] sz, input logic [31:0] a, d);
        @(posedge ref_clk);
        reqValid <= 1;
        reqWrite <= wr;
        reqFetch <= fe;
        reqSize <= sz;
        reqAddr <= a;
        reqWdata <= d;
        @(posedge ref_clk);
        reqValid <= 0;
        n = 0;
        drv = 0;
        // outputs are read at the edge after they change, before it updates them
        do begin
            @(posedge ref_clk);
            n++;
            drv |= !sharedDataOutEnN;
        end while (rspDone !== 1'b1 && n < 40);
        dab = dataAbortTrap;
        fab = fetchAbortTag;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        `CHK({fetch_not, translate_not, transfer_size, drive_out_enable_n, addrOutEnN, rspDone}, 7'h76)
        rst <= 0;
        foreach (rows[i]) begin
            big_endian_select <= rows[i][32];
            acc(0, 0, rows[i][36:35], {30'h0, rows[i][34:33]}, 0);
            `CHK(rspData, rows[i][31:0])
        end
        waits <= 1;
        acc(1, 0, 2, 32'h40, 32'hdeadbeef);
        `CHK(dataOut, 32'hdeadbeef)
        `CHK(n, 3)
        acc(0, 0, 2, 32'h44, 0);
        `CHK({dataOut, rspData}, {32'hdeadbeef, 32'h88776655})
        bus_split_select <= 0;
        acc(1, 0, 2, 32'h48, 32'h12345678);
        `CHK({sharedDataOut, drv, dataOut}, {32'h12345678, 1'b1, 32'h0})
        acc(0, 0, 2, 32'h4c, 0);
        `CHK(rspData, 32'h88776655)
        foreach (en[i]) begin
            {drive_in_gate_n, data_bus_enable, address_bus_enable, test_bus_enable} <= en[i];
            acc(1, 0, 2, 32'h50, 32'h0f0f0f0f);
            `CHK(drv, !en[i][3] && en[i][2] && en[i][0])
            `CHK(addrOutEnN, !(en[i][1] && en[i][0]))
        end
        bus_split_select <= 1;
        narrow <= 1;
        acc(0, 0, 2, 32'h8, 0);
        `CHK(rspData, 32'h88776655)
        narrow <= 0;
        waits <= 2;
        acc(0, 1, 2, 32'h80000010, 0);
        `CHK({n, fab, dab}, {32'd4, 2'h2})
        acc(0, 0, 0, 32'h80000011, 0);
        `CHK({fab, dab}, 2'h1)
        acc(0, 0, 2, 32'h40000014, 0);
        `CHK({fab, dab}, 2'h0)
        tally_and_finish();
    end
endmodule // tb

// ---- verilog/cdbi_data_bus.v ----
// data side bus interface: split/shared data buses, drive handshake,
// tristate controls, abort sampling, byte latches and read extraction.
// assumes core requests are synchronous to ref_clk; the falling edge of the
// main clock is modelled as the ref_clk edge that ends a bus cycle.
`include "cdbi_defs.vh"
//
// Contract
// - split mode reads from input data bus
// - read data captured at cycle end edge
// - output data changes only on split mode stores and on entering shared mode
// - shared mode ignores input data bus
// - shared mode holds output bus zero
// - write_not_read raised at the same edge that starts the write cycle
// - drive_out_enable_n low during write cycle
// - data_bus_enable low floats shared bus
// - test_bus_enable low floats address class outputs and shared bus
// - address_bus_enable floats address class outputs
// - test_bus_enable taken raw into the registered enables, one cycle late
// - abort sampled at end of bus cycle
// - data abort traps, fetch abort travels along
// - each byte_latch_enable bit gates one lane
// - extract addressed field per endian select
// - wait_n low stretches bus cycle whole clock
module cdbi_data_bus (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // configuration
    input  wire        bus_split_select,
    input  wire        big_endian_select,
    // core request side
    input  wire        reqValid,
    input  wire        reqWrite,
    input  wire        reqFetch,
    input  wire        reqUser,
    input  wire        reqLock,
    input  wire [1:0]  reqSize,
    input  wire [31:0] reqAddr,
    input  wire [31:0] reqWdata,
    // core answer side
    output reg         rspDone,
    output reg  [31:0] rspData,
    output reg         dataAbortTrap,
    output reg         fetchAbortTag,
    // memory address class outputs with enables (low = driving)
    output reg  [31:0] addrOut,
    output reg         write_not_read,
    output reg  [1:0]  transfer_size,
    output reg         fetch_not,
    output reg         translate_not,
    output reg         lockOut,
    output reg         addrOutEnN,
    // split data buses
    input  wire [31:0] dataIn,
    output reg  [31:0] dataOut,
    // shared data bus as three signals
    input  wire [31:0] sharedDataIn,
    output reg  [31:0] sharedDataOut,
    output reg         sharedDataOutEnN,
    output reg         drive_out_enable_n,
    // memory controls
    input  wire        drive_in_gate_n,
    input  wire        data_bus_enable,
    input  wire        address_bus_enable,
    input  wire        test_bus_enable,
    input  wire        wait_n,
    input  wire        abortIn,
    input  wire [3:0]  byte_latch_enable
);

    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    reg         state;
    reg         curWrite;
    reg         curFetch;
    reg  [1:0]  curSize;
    reg  [1:0]  curLow;
    reg  [31:0] busWord;
    reg  [31:0] field;
    reg         next_driveOutN;
    wire        laneCapture;
    wire [31:0] next_word;

    // lane source depends on bus mode; shared mode never looks at dataIn
    always @* begin
        if (bus_split_select) begin
            busWord = dataIn;
        end else begin
            busWord = sharedDataIn;
        end
    end

    // byte lanes latch at every busy edge of a read, wait_n or not, so narrow
    // memory can fill a word in parts while the cycle is stretched
    assign laneCapture = (state == ST_BUSY) & ~curWrite;

    // lane 3 carries the top byte, lane 0 the bottom byte
    cdbi_lane_latch #(
        .LANE_BITS (8)
    ) i_lane3 (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .capture  (laneCapture),
        .laneOpen (byte_latch_enable[3]),
        .laneIn   (busWord[`CDBI_LANE3]),
        .laneNext (next_word[`CDBI_LANE3])
    );

    cdbi_lane_latch #(
        .LANE_BITS (8)
    ) i_lane2 (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .capture  (laneCapture),
        .laneOpen (byte_latch_enable[2]),
        .laneIn   (busWord[`CDBI_LANE2]),
        .laneNext (next_word[`CDBI_LANE2])
    );

    cdbi_lane_latch #(
        .LANE_BITS (8)
    ) i_lane1 (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .capture  (laneCapture),
        .laneOpen (byte_latch_enable[1]),
        .laneIn   (busWord[`CDBI_LANE1]),
        .laneNext (next_word[`CDBI_LANE1])
    );

    cdbi_lane_latch #(
        .LANE_BITS (8)
    ) i_lane0 (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .capture  (laneCapture),
        .laneOpen (byte_latch_enable[0]),
        .laneIn   (busWord[`CDBI_LANE0]),
        .laneNext (next_word[`CDBI_LANE0])
    );

    // field extraction from the completed word, result right aligned
    always @* begin
        field = next_word;
        if (curSize == `CDBI_SIZE_HALF) begin
            if (curLow[1] ^ big_endian_select) begin
                field = {16'h0000, next_word[31:16]};
            end else begin
                field = {16'h0000, next_word[15:0]};
            end
        end else if (curSize == `CDBI_SIZE_BYTE) begin
            case (curLow ^ {2{big_endian_select}})
                2'b00:   field = {24'h000000, next_word[`CDBI_LANE0]};
                2'b01:   field = {24'h000000, next_word[`CDBI_LANE1]};
                2'b10:   field = {24'h000000, next_word[`CDBI_LANE2]};
                default: field = {24'h000000, next_word[`CDBI_LANE3]};
            endcase
        end
    end

    // drive direction decided one edge ahead, so the shared bus enable flips
    // at the same edge as drive_out_enable_n and never outlives the write;
    // a write that completes at once still gets one full driven cycle
    always @* begin
        next_driveOutN = drive_out_enable_n;
        if (state == ST_IDLE) begin
            if (reqValid) begin
                next_driveOutN = ~reqWrite;
            end
        end else if (wait_n) begin
            next_driveOutN = 1'b1;
        end
    end

    // tristate enables follow the pins combinationally in intent, but outputs must
    // come from flops, so they register each cycle; test_bus_enable is read raw
    always @(posedge ref_clk) begin
        if (rst) begin
            addrOutEnN       <= 1'b1;
            sharedDataOutEnN <= 1'b1;
        end else begin
            addrOutEnN <= ~(address_bus_enable & test_bus_enable);
            sharedDataOutEnN <= ~(~bus_split_select & ~next_driveOutN
                                  & ~drive_in_gate_n & data_bus_enable
                                  & test_bus_enable);
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state              <= ST_IDLE;
            curWrite           <= 1'b0;
            curFetch           <= 1'b0;
            curSize            <= `CDBI_SIZE_WORD;
            curLow             <= 2'b00;
            rspDone            <= 1'b0;
            rspData            <= 32'h00000000;
            dataAbortTrap      <= 1'b0;
            fetchAbortTag      <= 1'b0;
            addrOut            <= 32'h00000000;
            write_not_read     <= 1'b0;
            transfer_size      <= `CDBI_SIZE_WORD;
            fetch_not          <= 1'b1;
            translate_not      <= 1'b1;
            lockOut            <= 1'b0;
            dataOut            <= `CDBI_DOUT_RST;
            sharedDataOut      <= 32'h00000000;
            drive_out_enable_n <= 1'b1;
        end else begin
            rspDone       <= 1'b0;
            dataAbortTrap <= 1'b0;
            fetchAbortTag <= 1'b0;
            drive_out_enable_n <= next_driveOutN;
            if (!bus_split_select) begin
                dataOut <= `CDBI_DOUT_RST;
            end
            case (state)
                ST_IDLE: begin
                    if (reqValid) begin
                        // address class goes out at the same edge that starts the data cycle
                        addrOut        <= reqAddr;
                        write_not_read <= reqWrite;
                        transfer_size  <= reqSize;
                        fetch_not      <= ~reqFetch;
                        translate_not  <= ~reqUser;
                        lockOut        <= reqLock;
                        curWrite       <= reqWrite;
                        curFetch       <= reqFetch;
                        curSize        <= reqSize;
                        curLow         <= reqAddr[1:0];
                        if (reqWrite) begin
                            sharedDataOut <= reqWdata;
                            if (bus_split_select) begin
                                dataOut <= reqWdata;
                            end
                        end
                        state <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    // a low wait_n extends the cycle by a whole clock
                    if (wait_n) begin
                        rspDone            <= 1'b1;
                        rspData            <= curWrite ? 32'h00000000 : field;
                        write_not_read     <= 1'b0;
                        lockOut            <= 1'b0;
                        // abort only counts at the completing edge
                        if (abortIn) begin
                            dataAbortTrap <= ~curFetch;
                            fetchAbortTag <= curFetch;
                        end
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // cdbi_data_bus

// one byte lane of the read latch; the merged value is offered at once so
// the completing edge can extract a field that includes this cycle's bytes,
// while the held byte survives cycles in which the lane stays closed
module cdbi_lane_latch #(
    parameter LANE_BITS = 8
) (
    // clock and reset
    input  wire                 ref_clk,
    input  wire                 rst,
    // capture control
    input  wire                 capture,
    input  wire                 laneOpen,
    // lane data
    input  wire [LANE_BITS-1:0] laneIn,
    output reg  [LANE_BITS-1:0] laneNext
);

    reg [LANE_BITS-1:0] laneHeld;

    // a closed lane keeps its byte, which lets halfword memory fill in parts
    always @* begin
        if (laneOpen) begin
            laneNext = laneIn;
        end else begin
            laneNext = laneHeld;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            laneHeld <= {LANE_BITS{1'b0}};
        end else if (capture) begin
            laneHeld <= laneNext;
        end
    end

endmodule // cdbi_lane_latch
